//--- core/rphp_pkg.sv
// Constants and types shared by the root-port slot event logic.
// Assumes a single core clock domain; nothing outside this package is needed.
package rphp_pkg;

  // --------------------------------------------------------------------
  // Link rates and encodings
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    RPHP_RATE_2G5,
    RPHP_RATE_5G,
    RPHP_RATE_8G,
    RPHP_RATE_16G,
    RPHP_RATE_32G
  } rphp_rate_t;

  typedef enum logic {
    RPHP_ENC_8B10B,
    RPHP_ENC_128B130B
  } rphp_enc_t;

  // Port kinds: which rate ceiling applies
  typedef enum logic [1:0] {
    RPHP_PORT_X4_MOBILE,
    RPHP_PORT_X8_MOBILE,
    RPHP_PORT_X16_DESKTOP
  } rphp_port_kind_t;

  // --------------------------------------------------------------------
  // Strap positions and reset values
  // --------------------------------------------------------------------
  localparam int unsigned RPHP_STRAP_PORT0_BIT = 14;
  localparam int unsigned RPHP_STRAP_PORT1_BIT = 15;
  localparam int unsigned RPHP_LANES           = 4;
  localparam logic        RPHP_FLAG_RST        = 1'h0;
  localparam logic [7:0]  RPHP_LANE_SEL_RST    = 8'hE4;
  localparam logic        RPHP_STRAP_RST       = 1'h1;
  localparam logic        RPHP_SMI_N_RST       = 1'h1;

  // --------------------------------------------------------------------
  // Config translation
  // --------------------------------------------------------------------
  localparam int unsigned RPHP_CFG_AW       = 12;
  localparam logic [1:0]  RPHP_CFG_ALIGN_OK = 2'h0;

endpackage

//--- core/rphp_lane_map.sv
// Lane remapping for one 4-lane port, registered.
// Assumes the strap is already captured and stable in the core clock domain.
`timescale 1ns/100ps
`default_nettype none
module rphp_lane_map (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       strap_straight,
  output var  logic [7:0] lane_sel_q
);

  // --------------------------------------------------------------------
  // Lane map
  // --------------------------------------------------------------------
  // Logical lane i takes physical lane i, or 3-i when reversed
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lane_sel_q <= rphp_pkg::RPHP_LANE_SEL_RST;
    end else begin
      for (int i = 0; i < rphp_pkg::RPHP_LANES; i++) begin
        lane_sel_q[2*i +: 2] <= strap_straight ? 2'(i) : 2'(3 - i);
      end
    end
  end

endmodule
`default_nettype wire

//--- core/rphp_slot_events.sv
// Root-port slot event logic: presence, change flags, interrupt, SCI, SMI,
// lane reversal straps, rate/encoding limits and config-cycle translation.
// Assumes presence and link-active inputs come from the PHY (asynchronous)
// and that software controls arrive on the core clock.
`timescale 1ns/100ps
`default_nettype none
module rphp_slot_events (
  input  wire logic                           core_clk,
  input  wire logic                           resetn,
  input  wire logic                           phy_present,
  input  wire logic                           phy_link_active,
  input  wire logic                           presence_change_irq_enable,
  input  wire logic                           hotplug_irq_enable,
  input  wire logic                           hotplug_sci_enable,
  input  wire logic                           hotplug_smi_enable,
  input  wire logic                           clr_presence_changed,
  input  wire logic                           clr_sci_status,
  input  wire logic                           clr_smi_presence,
  input  wire logic                           clr_smi_link,
  input  wire logic [15:0]                    cfg_straps,
  input  wire logic                           strap_capture,
  input  wire rphp_pkg::rphp_port_kind_t      port_kind,
  input  wire rphp_pkg::rphp_rate_t           rate_request,
  input  wire logic                           cfg_req,
  input  wire logic                           cfg_wr,
  input  wire logic [11:0]                    cfg_addr,
  input  wire logic [31:0]                    cfg_wdata,
  output var  logic                           slot_presence_state,
  output var  logic                           slot_presence_changed,
  output var  logic                           port_irq,
  output var  logic                           hotplug_sci_status,
  output var  logic                           smi_presence_changed_status,
  output var  logic                           smi_link_active_changed_status,
  output var  logic                           system_mgmt_irq_n,
  output var  logic [7:0]                     port0_lane_sel,
  output var  logic [7:0]                     port1_lane_sel,
  output var  rphp_pkg::rphp_rate_t           link_rate,
  output var  rphp_pkg::rphp_enc_t            link_encoding,
  output var  logic                           link_cfg_valid,
  output var  logic                           link_cfg_wr,
  output var  logic [11:0]                    link_cfg_addr,
  output var  logic [31:0]                    link_cfg_wdata,
  output var  logic                           cfg_misaligned
);

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  logic pres_meta_q, pres_sync_q, pres_last_q;
  logic link_meta_q, link_sync_q, link_last_q;

  // Two flops per asynchronous PHY level, then a history flop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pres_meta_q <= 1'h0;
      pres_sync_q <= 1'h0;
      pres_last_q <= 1'h0;
      link_meta_q <= 1'h0;
      link_sync_q <= 1'h0;
      link_last_q <= 1'h0;
    end else begin
      pres_meta_q <= phy_present;
      pres_sync_q <= pres_meta_q;
      pres_last_q <= pres_sync_q;
      link_meta_q <= phy_link_active;
      link_sync_q <= link_meta_q;
      link_last_q <= link_sync_q;
    end
  end

  logic ins_evt, rem_evt, pres_evt, link_evt;
  assign ins_evt  = pres_sync_q & ~pres_last_q;
  assign rem_evt  = ~pres_sync_q & pres_last_q;
  assign pres_evt = ins_evt | rem_evt;
  assign link_evt = link_sync_q ^ link_last_q;

  // --------------------------------------------------------------------
  // Slot status
  // --------------------------------------------------------------------
  // Presence follows the detected module; changed flag is sticky
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      slot_presence_state <= rphp_pkg::RPHP_FLAG_RST;
    end else if (ins_evt) begin
      slot_presence_state <= 1'h1;
    end else if (rem_evt) begin
      slot_presence_state <= 1'h0;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      slot_presence_changed <= rphp_pkg::RPHP_FLAG_RST;
    end else if (pres_evt) begin
      slot_presence_changed <= 1'h1;
    end else if (clr_presence_changed) begin
      slot_presence_changed <= 1'h0;
    end
  end

  // Port interrupt level while flag and both enables hold
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      port_irq <= 1'h0;
    end else begin
      port_irq <= (slot_presence_changed | pres_evt) & presence_change_irq_enable
                  & hotplug_irq_enable;
    end
  end

  // --------------------------------------------------------------------
  // SCI and SMI status
  // --------------------------------------------------------------------
  // SCI status from enabled hot-plug events
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hotplug_sci_status <= rphp_pkg::RPHP_FLAG_RST;
    end else if (hotplug_sci_enable && (pres_evt || link_evt)) begin
      hotplug_sci_status <= 1'h1;
    end else if (clr_sci_status) begin
      hotplug_sci_status <= 1'h0;
    end
  end

  // SMI status, independent of interrupt and SCI enables
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      smi_presence_changed_status    <= rphp_pkg::RPHP_FLAG_RST;
      smi_link_active_changed_status <= rphp_pkg::RPHP_FLAG_RST;
    end else begin
      if (hotplug_smi_enable && pres_evt) begin
        smi_presence_changed_status <= 1'h1;
      end else if (clr_smi_presence) begin
        smi_presence_changed_status <= 1'h0;
      end
      if (hotplug_smi_enable && link_evt) begin
        smi_link_active_changed_status <= 1'h1;
      end else if (clr_smi_link) begin
        smi_link_active_changed_status <= 1'h0;
      end
    end
  end

  // Active-low SMI from either status, registered from the status flags so it follows them a cycle later
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      system_mgmt_irq_n <= rphp_pkg::RPHP_SMI_N_RST;
    end else begin
      system_mgmt_irq_n <= ~(smi_presence_changed_status
                             | smi_link_active_changed_status);
    end
  end

  // --------------------------------------------------------------------
  // Lane reversal straps
  // --------------------------------------------------------------------
  logic strap0_q, strap1_q;

  // Straps captured on request after reset release; default straight
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      strap0_q <= rphp_pkg::RPHP_STRAP_RST;
      strap1_q <= rphp_pkg::RPHP_STRAP_RST;
    end else if (strap_capture) begin
      strap0_q <= cfg_straps[rphp_pkg::RPHP_STRAP_PORT0_BIT];
      strap1_q <= cfg_straps[rphp_pkg::RPHP_STRAP_PORT1_BIT];
    end
  end

  rphp_lane_map u_map0 (
    .core_clk       (core_clk),
    .resetn         (resetn),
    .strap_straight (strap0_q),
    .lane_sel_q     (port0_lane_sel)
  );

  rphp_lane_map u_map1 (
    .core_clk       (core_clk),
    .resetn         (resetn),
    .strap_straight (strap1_q),
    .lane_sel_q     (port1_lane_sel)
  );

  // --------------------------------------------------------------------
  // Rate limits and encoding
  // --------------------------------------------------------------------
  rphp_pkg::rphp_rate_t rate_d;

  // Only the desktop 16-lane port may reach 32 GT/s
  always_comb begin
    rate_d = rate_request;
    if (rate_request == rphp_pkg::RPHP_RATE_32G
        && port_kind != rphp_pkg::RPHP_PORT_X16_DESKTOP) begin
      rate_d = rphp_pkg::RPHP_RATE_16G;
    end else if (rate_request > rphp_pkg::RPHP_RATE_32G) begin
      rate_d = rphp_pkg::RPHP_RATE_2G5;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      link_rate     <= rphp_pkg::RPHP_RATE_2G5;
      link_encoding <= rphp_pkg::RPHP_ENC_8B10B;
    end else begin
      link_rate     <= rate_d;
      link_encoding <= (rate_d == rphp_pkg::RPHP_RATE_2G5
                        || rate_d == rphp_pkg::RPHP_RATE_5G)
                       ? rphp_pkg::RPHP_ENC_8B10B
                       : rphp_pkg::RPHP_ENC_128B130B;
    end
  end

  // --------------------------------------------------------------------
  // Config access translation
  // --------------------------------------------------------------------
  // One-cycle link config cycle per host request; misalignment flagged
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      link_cfg_valid <= 1'h0;
      link_cfg_wr    <= 1'h0;
      link_cfg_addr  <= 12'h000;
      link_cfg_wdata <= 32'h0000_0000;
      cfg_misaligned <= 1'h0;
    end else begin
      link_cfg_valid <= cfg_req;
      if (cfg_req) begin
        link_cfg_wr    <= cfg_wr;
        link_cfg_addr  <= cfg_addr;
        link_cfg_wdata <= cfg_wdata;
        cfg_misaligned <= cfg_addr[1:0] != rphp_pkg::RPHP_CFG_ALIGN_OK;
      end
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_ins_sets_state: assert property (ins_evt |=> slot_presence_state && slot_presence_changed)
    else $error("insertion did not set presence");
  a_rem_clears_state: assert property (rem_evt |=> !slot_presence_state && slot_presence_changed)
    else $error("removal did not clear presence");
  a_irq_needs_enables: assert property (port_irq |-> $past(presence_change_irq_enable && hotplug_irq_enable))
    else $error("port interrupt without enables");
  a_sci_from_event: assert property (hotplug_sci_enable && link_evt |=> hotplug_sci_status)
    else $error("sci status not set");
  a_smi_pres_map: assert property (hotplug_smi_enable && pres_evt |=> smi_presence_changed_status)
    else $error("smi presence status not set");
  a_smi_link_map: assert property ($rose(smi_link_active_changed_status) |-> $past(link_evt))
    else $error("smi link status without link event");
  a_smi_pin: assert property (smi_presence_changed_status |=> !system_mgmt_irq_n)
    else $error("smi output not asserted");
  a_flag_sticky: assert property (slot_presence_changed && !clr_presence_changed |=> slot_presence_changed)
    else $error("changed flag dropped");
  a_enc_rule: assert property (link_rate == rphp_pkg::RPHP_RATE_8G |-> link_encoding == rphp_pkg::RPHP_ENC_128B130B)
    else $error("wrong encoding");
  a_rate_cap: assert property (port_kind != rphp_pkg::RPHP_PORT_X16_DESKTOP |=> link_rate != rphp_pkg::RPHP_RATE_32G)
    else $error("rate over cap");
  a_cfg_cycle: assert property (cfg_req |=> link_cfg_valid && link_cfg_addr == $past(cfg_addr))
    else $error("config cycle missing");
  a_lane_rev: assert property (strap_capture && !cfg_straps[rphp_pkg::RPHP_STRAP_PORT0_BIT] |-> ##2 port0_lane_sel == 8'h1B)
    else $error("lane reversal wrong");

  c_insert: cover property (ins_evt ##[1:20] rem_evt);
  c_all_three: cover property (port_irq && hotplug_sci_status && !system_mgmt_irq_n);
  c_clear_race: cover property (pres_evt && clr_presence_changed);
  c_rate32: cover property (link_rate == rphp_pkg::RPHP_RATE_32G);

endmodule
`default_nettype wire

//--- verif/rphp_slot_model.sv
// Behavioural model of the module or endpoint that sits in the slot.
// Assumes the bench commands insertion and link state, with a short or long settling time.
`timescale 1ns/100ps
`default_nettype none
module rphp_slot_model (
  input  wire logic core_clk,
  input  wire logic want_present,
  input  wire logic want_link,
  input  wire logic slow,
  output var  logic phy_present,
  output var  logic phy_link_active
);
  // ------------------------------------------------------------------
  // Presence and link pins
  // ------------------------------------------------------------------
  int unsigned wait_q;

  initial begin
    phy_present = 1'b0;
    phy_link_active = 1'b0;
    wait_q = 0;
  end

  // Follow the commanded state after a settling time; link needs a module
  always @(posedge core_clk) begin
    if ({want_present, want_link & want_present} == {phy_present, phy_link_active}) begin
      wait_q <= 0;
    end else if (wait_q >= (slow ? 6 : 1)) begin
      phy_present     <= want_present;
      phy_link_active <= want_link & want_present;
      wait_q          <= 0;
    end else begin
      wait_q <= wait_q + 1;
    end
  end
endmodule
`default_nettype wire

//--- verif/rphp_slot_events_tb_top.sv
// Self-checking bench for the slot event logic, straps, rates and config path.
// Assumes the package, the design and the slot model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end
module rphp_slot_events_tb_top;
  // ------------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------------
  logic                      core_clk = 1'b0;
  logic                      resetn = 1'b0;
  logic                      pde, hpe, sci_en, smi_en, want_p, want_l, slow, cap, req, wr;
  logic [3:0]                clr;
  logic [15:0]               straps;
  logic [11:0]               addr, caddr;
  logic [31:0]               wdata, cdata;
  rphp_pkg::rphp_port_kind_t kind;
  rphp_pkg::rphp_rate_t      rate, lrate;
  rphp_pkg::rphp_enc_t       lenc;
  wire logic                 phy_p, phy_l;
  logic                      pres, chg, irq, sci_st, smi_p, smi_l, smi_n, cvalid, cwr, cmis;
  logic [7:0]                ln0, ln1;
  int                        n_mismatch, compares, er;

  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;

  rphp_slot_model model (.core_clk(core_clk), .want_present(want_p), .want_link(want_l),
    .slow(slow), .phy_present(phy_p), .phy_link_active(phy_l));

  rphp_slot_events uut (.core_clk(core_clk), .resetn(resetn), .phy_present(phy_p),
    .phy_link_active(phy_l), .presence_change_irq_enable(pde), .hotplug_irq_enable(hpe),
    .hotplug_sci_enable(sci_en), .hotplug_smi_enable(smi_en),
    .clr_presence_changed(clr[0]), .clr_sci_status(clr[1]), .clr_smi_presence(clr[2]),
    .clr_smi_link(clr[3]), .cfg_straps(straps), .strap_capture(cap), .port_kind(kind),
    .rate_request(rate), .cfg_req(req), .cfg_wr(wr), .cfg_addr(addr), .cfg_wdata(wdata),
    .slot_presence_state(pres), .slot_presence_changed(chg), .port_irq(irq),
    .hotplug_sci_status(sci_st), .smi_presence_changed_status(smi_p),
    .smi_link_active_changed_status(smi_l), .system_mgmt_irq_n(smi_n),
    .port0_lane_sel(ln0), .port1_lane_sel(ln1), .link_rate(lrate), .link_encoding(lenc),
    .link_cfg_valid(cvalid), .link_cfg_wr(cwr), .link_cfg_addr(caddr),
    .link_cfg_wdata(cdata), .cfg_misaligned(cmis));

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  // Print the counts and the verdict, then stop
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic done(input string t);
    $display("test %0s finished", t);
  endtask

  // Wait, bounded, for the presence or link flag, then let the interrupt land
  task automatic wait_evt(input bit on_link);
    for (int k = 0; k < 30; k++) begin
      if ((on_link ? smi_l : chg) === 1'b1) break;
      @(negedge core_clk);
    end
    repeat (2) @(negedge core_clk);
  endtask

  // One-cycle write-one-clear pulse
  task automatic clear(input logic [3:0] m);
    clr = m;
    @(negedge core_clk);
    clr = 4'h0;
    repeat (2) @(negedge core_clk);
  endtask

  // One host config access and its forwarded cycle
  task automatic cfg_go(input logic [11:0] a, input logic [31:0] d, input logic w);
    req = 1'b1;
    addr = a;
    wdata = d;
    wr = w;
    @(negedge core_clk);
    req = 1'b0;
    `CHK("cfg valid", 1'b1, cvalid)
    `CHK("cfg addr", a, caddr)
    `CHK("cfg data", d, cdata)
    `CHK("cfg wr", w, cwr)
    `CHK("cfg misaligned", (a[1:0] != 2'h0), cmis)
    @(negedge core_clk);
    `CHK("cfg one cycle", 1'b0, cvalid)
  endtask

  // Watchdog: the tests need well under 1000 cycles
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    compares = 0;
    {pde, hpe, sci_en, smi_en, want_p, want_l, slow, cap, req, wr} = '0;
    clr = 4'h0;
    straps = 16'hFFFF;
    addr = 12'h000;
    wdata = 32'h0;
    kind = rphp_pkg::RPHP_PORT_X4_MOBILE;
    rate = rphp_pkg::RPHP_RATE_2G5;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    @(negedge core_clk);
    `CHK("lane0 reset", 8'hE4, ln0)
    `CHK("smi idle", 1'b1, smi_n)
    done("reset");
    // Slow insertion, only the SMI path enabled
    smi_en = 1'b1;
    slow = 1'b1;
    want_p = 1'b1;
    wait_evt(1'b0);
    `CHK("present", 1'b1, pres)
    `CHK("changed", 1'b1, chg)
    `CHK("smi presence", 1'b1, smi_p)
    `CHK("smi link", 1'b0, smi_l)
    `CHK("sci off", 1'b0, sci_st)
    `CHK("irq off", 1'b0, irq)
    `CHK("smi out", 1'b0, smi_n)
    clear(4'h5);
    `CHK("changed clr", 1'b0, chg)
    `CHK("smi out clr", 1'b1, smi_n)
    done("insert");
    // Link comes up quickly
    slow = 1'b0;
    want_l = 1'b1;
    wait_evt(1'b1);
    `CHK("smi link set", 1'b1, smi_l)
    `CHK("smi pres quiet", 1'b0, smi_p)
    `CHK("smi out link", 1'b0, smi_n)
    clear(4'h8);
    done("link");
    // Removal with every path enabled
    {pde, hpe, sci_en} = 3'h7;
    {want_p, want_l} = 2'h0;
    wait_evt(1'b0);
    `CHK("removed", 1'b0, pres)
    `CHK("changed rm", 1'b1, chg)
    `CHK("irq", 1'b1, irq)
    `CHK("sci", 1'b1, sci_st)
    `CHK("smi all", 1'b1, smi_p)
    `CHK("smi together", 1'b0, smi_n)
    repeat (5) @(negedge core_clk);
    `CHK("irq held", 1'b1, irq)
    hpe = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK("irq gated", 1'b0, irq)
    clear(4'hF);
    `CHK("flags clr", 4'h0, {chg, sci_st, smi_p, smi_l})
    done("removal");
    // Insertion with SMI and SCI disabled
    {hpe, sci_en, smi_en} = 3'h4;
    want_p = 1'b1;
    wait_evt(1'b0);
    `CHK("irq only", 1'b1, irq)
    `CHK("no smi", 2'h0, {smi_p, sci_st})
    `CHK("smi quiet", 1'b1, smi_n)
    clear(4'h1);
    done("irq_only");
    // Lane straps, both polarities on both ports
    for (int s = 0; s < 2; s++) begin
      straps = s ? 16'h7FFF : 16'hBFFF;
      cap = 1'b1;
      @(negedge core_clk);
      cap = 1'b0;
      repeat (2) @(negedge core_clk);
      `CHK("lane0", s ? 8'hE4 : 8'h1B, ln0)
      `CHK("lane1", s ? 8'h1B : 8'hE4, ln1)
    end
    done("straps");
    // Every rate code, unused codes too, on every port kind
    for (int k = 0; k < 3; k++) begin
      for (int r = 0; r < 8; r++) begin
        kind = rphp_pkg::rphp_port_kind_t'(k);
        rate = rphp_pkg::rphp_rate_t'(r);
        @(negedge core_clk);
        er = (r > 4) ? 0 : ((r == 4 && k != 2) ? 3 : r);
        `CHK("rate", rphp_pkg::rphp_rate_t'(er), lrate)
        `CHK("enc", rphp_pkg::rphp_enc_t'(er >= 2), lenc)
      end
    end
    done("rates");
    // Aligned write, then a misaligned read
    cfg_go(12'h104, 32'hA5A50F0F, 1'b1);
    cfg_go(12'h0FE, 32'h00000000, 1'b0);
    done("config");
    conclude();
  end
endmodule
`undef CHK
`default_nettype wire
